// ---- mtp_motor_thermal.sv ----
module mtp_motor_thermal
#(
   parameter int CTRL_PERIOD_CYC = mtp_pkg::CTRL_PERIOD_CYC
)
(
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   input  wire logic [15:0] output_current_in,
   input  wire logic [15:0] thermistor_ohm_in,
   input  wire logic        second_set_select_in,
   input  wire logic        external_overheat_in,
   input  wire logic        fault_reset_in,
   input  wire logic [15:0] extended_display_select_in,
   input  wire logic        setting_wr_in,
   input  wire logic [2:0]  setting_sel_in,
   input  wire logic [15:0] setting_data_in,
   output logic             setting_rejected_out,
   output logic             heat_prealarm_out,
   output logic             prealarm_display_out,
   output logic             motor_overload_fault_out,
   output logic             transistor_overload_fault_out,
   output logic             external_relay_fault_out,
   output logic             thermistor_fault_out,
   output logic             trip_out,
   output logic             second_function_out,
   output logic             analog_cmd_enable_out,
   output logic             thermistor_monitor_valid_out,
   output logic [15:0]      thermistor_monitor_out,
   output logic [15:0]      first_overload_level_out,
   output logic [15:0]      second_overload_level_out,
   output logic [15:0]      motor_type_select_out,
   output logic [15:0]      second_motor_type_out,
   output logic [15:0]      thermistor_trip_level_out
);

   typedef struct packed
   {
      logic [31:0] tick_cnt;
      logic        tick;
      logic        rt_s1;
      logic        rt_s2;
      logic        oh_s1;
      logic        oh_s2;
      logic        rst_s1;
      logic        rst_s2;
      logic [15:0] first_level;
      logic [15:0] second_level;
      logic [15:0] motor_type;
      logic [15:0] second_type;
      logic [15:0] therm_level;
      logic        rejected;
      logic        motor_fault;
      logic        trans_fault;
      logic        relay_fault;
      logic        therm_fault;
      logic        prealarm;
      logic [15:0] therm_mon;
      logic        therm_mon_valid;
   } mtp_state_s;

   mtp_state_s  state_reg;
   mtp_state_s  state_next;

   logic        first_en;
   logic        second_en;
   logic        rt_effective;
   logic        first_active;
   logic        second_active;
   logic        therm_en;
   logic [15:0] second_level_eff;
   logic [3:0]  first_shift;
   logic [3:0]  second_shift;
   logic        first_pre;
   logic        first_trip;
   logic        second_pre;
   logic        second_trip;
   logic        trans_pre;
   logic        trans_trip;
   logic        write_ok;

   // codes accepted by the first motor type setting
   function automatic logic motor_code_ok(input logic [15:0] code);
      case (code)
         mtp_pkg::MT_STD0,
         mtp_pkg::MT_CT1,
         mtp_pkg::MT_STD3,
         mtp_pkg::MT_CT13,
         mtp_pkg::MT_STD23,
         mtp_pkg::MT_STD40,
         mtp_pkg::MT_STD43,
         mtp_pkg::MT_CT50,
         mtp_pkg::MT_CT53: motor_code_ok = 1'b1;
         default:          motor_code_ok = 1'b0;
      endcase
   endfunction

   // thermal characteristic per motor code; constant-torque motors run a slower curve
   function automatic logic [3:0] char_shift(input logic [15:0] code);
      case (code)
         mtp_pkg::MT_CT1,
         mtp_pkg::MT_CT13,
         mtp_pkg::MT_CT50,
         mtp_pkg::MT_CT53: char_shift = mtp_pkg::SHIFT_CONST_TORQUE;
         default:          char_shift = mtp_pkg::SHIFT_STANDARD;
      endcase
   endfunction

   // an overload level that makes its accumulator run: 0.01 A up to 500 A
   function automatic logic level_runs(input logic [15:0] level);
      level_runs = (level != 16'h0000) && (level <= mtp_pkg::LEVEL_MAX);
   endfunction

   // which accumulator heats, which cools, which is off
   always_comb
   begin
      first_en     = level_runs(state_reg.first_level);
      // second type enabled and second level unset: second motor reuses the first level
      if ((state_reg.second_level == mtp_pkg::DISABLE_CODE) &&
          (state_reg.second_type != mtp_pkg::DISABLE_CODE))
         second_level_eff = state_reg.first_level;
      else
         second_level_eff = state_reg.second_level;
      second_en    = level_runs(second_level_eff);
      // with both second settings at the disable code the select input is ignored here
      rt_effective = state_reg.rt_s2 &&
                     !((state_reg.second_level == mtp_pkg::DISABLE_CODE) &&
                       (state_reg.second_type == mtp_pkg::DISABLE_CODE));
      first_active  = !rt_effective;
      second_active = rt_effective;
      first_shift  = char_shift(state_reg.motor_type);
      if (state_reg.second_type == mtp_pkg::DISABLE_CODE)
         second_shift = first_shift;
      else
         second_shift = char_shift(state_reg.second_type);
      therm_en     = state_reg.therm_level != mtp_pkg::DISABLE_CODE;
   end

   // motor type settings only change while the extended display select is zero
   always_comb
   begin
      case (setting_sel_in)
         mtp_pkg::SEL_FIRST_LEVEL:
            write_ok = setting_data_in <= mtp_pkg::LEVEL_MAX;
         mtp_pkg::SEL_SECOND_LEVEL:
            write_ok = (setting_data_in <= mtp_pkg::LEVEL_MAX) ||
                       (setting_data_in == mtp_pkg::DISABLE_CODE);
         mtp_pkg::SEL_MOTOR_TYPE:
            write_ok = (extended_display_select_in == 16'h0000) &&
                       motor_code_ok(setting_data_in);
         mtp_pkg::SEL_SECOND_TYPE:
            write_ok = (extended_display_select_in == 16'h0000) &&
                       ((setting_data_in == mtp_pkg::MT_STD0) ||
                        (setting_data_in == mtp_pkg::MT_CT1) ||
                        (setting_data_in == mtp_pkg::DISABLE_CODE));
         mtp_pkg::SEL_THERM_LEVEL:
            write_ok = ((setting_data_in >= mtp_pkg::THERM_MIN) &&
                        (setting_data_in <= mtp_pkg::THERM_MAX)) ||
                       (setting_data_in == mtp_pkg::DISABLE_CODE);
         default:
            write_ok = 1'b0;
      endcase
   end

   mtp_thermal_acc first_acc
   (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .tick_in      (state_reg.tick),
      .enable_in    (first_en && !state_reg.rst_s2),
      .heating_in   (first_active),
      .current_in   (output_current_in),
      .level_in     (state_reg.first_level),
      .shift_in     (first_shift),
      .prealarm_out (first_pre),
      .trip_out     (first_trip)
   );

   mtp_thermal_acc second_acc
   (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .tick_in      (state_reg.tick),
      .enable_in    (second_en && !state_reg.rst_s2),
      .heating_in   (second_active),
      .current_in   (output_current_in),
      .level_in     (second_level_eff),
      .shift_in     (second_shift),
      .prealarm_out (second_pre),
      .trip_out     (second_trip)
   );

   // output stage protection runs on the drive rating regardless of the motor levels
   mtp_thermal_acc transistor_acc
   (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .tick_in      (state_reg.tick),
      .enable_in    (!state_reg.rst_s2),
      .heating_in   (1'b1),
      .current_in   (output_current_in),
      .level_in     (mtp_pkg::DRIVE_RATED_LEVEL),
      .shift_in     (mtp_pkg::SHIFT_TRANSISTOR),
      .prealarm_out (trans_pre),
      .trip_out     (trans_trip)
   );

   // next state of the supervisor
   always_comb
   begin
      state_next = state_reg;

      // fixed control period tick
      if (state_reg.tick_cnt >= 32'(CTRL_PERIOD_CYC - 1))
      begin
         state_next.tick_cnt = 32'h0;
         state_next.tick     = 1'b1;
      end
      else
      begin
         state_next.tick_cnt = state_reg.tick_cnt + 32'h1;
         state_next.tick     = 1'b0;
      end

      // pins pass two flops before anything reads them
      state_next.rt_s1  = second_set_select_in;
      state_next.rt_s2  = state_reg.rt_s1;
      state_next.oh_s1  = external_overheat_in;
      state_next.oh_s2  = state_reg.oh_s1;
      state_next.rst_s1 = fault_reset_in;
      state_next.rst_s2 = state_reg.rst_s1;

      // settings; an invalid value or locked setting is dropped and flagged
      state_next.rejected = setting_wr_in && !write_ok;
      if (setting_wr_in && write_ok)
      begin
         case (setting_sel_in)
            mtp_pkg::SEL_FIRST_LEVEL:  state_next.first_level  = setting_data_in;
            mtp_pkg::SEL_SECOND_LEVEL: state_next.second_level = setting_data_in;
            mtp_pkg::SEL_MOTOR_TYPE:   state_next.motor_type   = setting_data_in;
            mtp_pkg::SEL_SECOND_TYPE:  state_next.second_type  = setting_data_in;
            mtp_pkg::SEL_THERM_LEVEL:  state_next.therm_level  = setting_data_in;
            default:                   state_next.therm_level  = state_reg.therm_level;
         endcase
      end

      // prealarm follows the accumulator that carries the real current
      state_next.prealarm = rt_effective ? second_pre : first_pre;

      // latched faults: reset input clears, a fresh cause in the same cycle wins
      if (state_reg.rst_s2)
      begin
         state_next.motor_fault = 1'b0;
         state_next.trans_fault = 1'b0;
         state_next.relay_fault = 1'b0;
         state_next.therm_fault = 1'b0;
      end
      if (first_trip || second_trip)
         state_next.motor_fault = 1'b1;
      if (trans_trip)
         state_next.trans_fault = 1'b1;
      if (state_reg.oh_s2)
         state_next.relay_fault = 1'b1;
      if (therm_en && (thermistor_ohm_in >= state_reg.therm_level))
         state_next.therm_fault = 1'b1;

      // resistance monitor hidden while thermistor protection is off
      state_next.therm_mon_valid = therm_en;
      state_next.therm_mon       = therm_en ? thermistor_ohm_in : 16'h0000;
   end

   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_reg              <= '0;
         state_reg.first_level  <= mtp_pkg::FIRST_LEVEL_RST;
         state_reg.second_level <= mtp_pkg::SECOND_LEVEL_RST;
         state_reg.motor_type   <= mtp_pkg::MOTOR_TYPE_RST;
         state_reg.second_type  <= mtp_pkg::SECOND_TYPE_RST;
         state_reg.therm_level  <= mtp_pkg::THERM_LEVEL_RST;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs; the prealarm has no path into the trip
   assign setting_rejected_out          = state_reg.rejected;
   assign heat_prealarm_out             = state_reg.prealarm;
   assign prealarm_display_out          = state_reg.prealarm;
   assign motor_overload_fault_out      = state_reg.motor_fault;
   assign transistor_overload_fault_out = state_reg.trans_fault;
   assign external_relay_fault_out      = state_reg.relay_fault;
   assign thermistor_fault_out          = state_reg.therm_fault;
   assign trip_out                      = state_reg.motor_fault | state_reg.trans_fault |
                                          state_reg.relay_fault | state_reg.therm_fault;
   assign second_function_out           = state_reg.rt_s2;
   assign analog_cmd_enable_out         = !therm_en;
   assign thermistor_monitor_valid_out  = state_reg.therm_mon_valid;
   assign thermistor_monitor_out        = state_reg.therm_mon;
   assign first_overload_level_out      = state_reg.first_level;
   assign second_overload_level_out     = state_reg.second_level;
   assign motor_type_select_out         = state_reg.motor_type;
   assign second_motor_type_out         = state_reg.second_type;
   assign thermistor_trip_level_out     = state_reg.therm_level;

endmodule

// ---- mtp_pkg.sv ----
// What this block does
// - second-set select on: overload protection uses the second overload level
// - separate second-motor accumulator heats only when selected and its effective level valid
// - active accumulator integrates the real measured output current
// - enabled but unselected accumulator integrates zero current, so it cools
// - disabled accumulator neither integrates nor raises prealarm or trip
// - second motor type at disable code: first motor characteristic applies
// - second motor type accepts 0 or 1, reset default is disable code
// - prealarm output and display at 85 percent of selected level
// - at 100 percent the drive trips with motor or transistor overload fault
// - prealarm alone never trips the drive
// - external thermal relay input active trips with external relay fault
// - thermistor resistance at trip level trips with thermistor fault
// - thermistor protection enabled: shared analog input is no frequency command
// - thermistor resistance readable only while thermistor protection is enabled
// - motor type accepts 0,1,3,13,23,40,43,50,53, reset default 0
// - motor type settings writable only while extended display select is 0
// - second-set select also enables every other second-set function
// - first level zero disables first accumulator, transistor protection stays
// - second level at disable code makes second level invalid
// - thermal trip cleared only by power cycle or reset input
package mtp_pkg;

   // setting selectors on the write port
   localparam logic [2:0]  SEL_FIRST_LEVEL     = 3'h0;
   localparam logic [2:0]  SEL_SECOND_LEVEL    = 3'h1;
   localparam logic [2:0]  SEL_MOTOR_TYPE      = 3'h2;
   localparam logic [2:0]  SEL_SECOND_TYPE     = 3'h3;
   localparam logic [2:0]  SEL_THERM_LEVEL     = 3'h4;

   // the printed disable code 9999 is carried as all ones on the 16-bit port
   localparam logic [15:0] DISABLE_CODE        = 16'hffff;

   // levels in 0.01 A units, resistance in 10 ohm units
   localparam logic [15:0] LEVEL_MAX           = 16'hc350;  // 500.00 A
   localparam logic [15:0] THERM_MIN           = 16'h0032;  // 0.50 kohm
   localparam logic [15:0] THERM_MAX           = 16'h0bb8;  // 30 kohm
   localparam logic [15:0] DRIVE_RATED_LEVEL   = 16'h01f4;  // plain default rating

   // reset values
   localparam logic [15:0] FIRST_LEVEL_RST     = DRIVE_RATED_LEVEL;
   localparam logic [15:0] SECOND_LEVEL_RST    = DISABLE_CODE;
   localparam logic [15:0] MOTOR_TYPE_RST      = 16'h0000;
   localparam logic [15:0] SECOND_TYPE_RST     = DISABLE_CODE;
   localparam logic [15:0] THERM_LEVEL_RST     = DISABLE_CODE;

   // motor type codes
   localparam logic [15:0] MT_STD0             = 16'h0000;
   localparam logic [15:0] MT_CT1              = 16'h0001;
   localparam logic [15:0] MT_STD3             = 16'h0003;
   localparam logic [15:0] MT_CT13             = 16'h000d;
   localparam logic [15:0] MT_STD23            = 16'h0017;
   localparam logic [15:0] MT_STD40            = 16'h0028;
   localparam logic [15:0] MT_STD43            = 16'h002b;
   localparam logic [15:0] MT_CT50             = 16'h0032;
   localparam logic [15:0] MT_CT53             = 16'h0035;

   // cooling shift per characteristic: larger shift means slower heating and cooling
   localparam logic [3:0]  SHIFT_STANDARD      = 4'h6;
   localparam logic [3:0]  SHIFT_CONST_TORQUE  = 4'h8;
   localparam logic [3:0]  SHIFT_TRANSISTOR    = 4'h4;

   // prealarm ratio 85/100 reduced to 17/20
   localparam logic [7:0]  PRE_NUM             = 8'h11;
   localparam logic [7:0]  PRE_DEN             = 8'h14;

   // control period
   localparam int          CLK_PERIOD_NS       = 50;
   localparam int          CTRL_PERIOD_US      = 1000;
   localparam int          CTRL_PERIOD_CYC     = (CTRL_PERIOD_US * 1000) / CLK_PERIOD_NS;

endpackage

// ---- mtp_thermal_acc.sv ----
module mtp_thermal_acc
(
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   input  wire logic        tick_in,
   input  wire logic        enable_in,
   input  wire logic        heating_in,
   input  wire logic [15:0] current_in,
   input  wire logic [15:0] level_in,
   input  wire logic [3:0]  shift_in,
   output logic             prealarm_out,
   output logic             trip_out
);

   typedef struct packed
   {
      logic [47:0] acc;
      logic        pre;
      logic        trip;
   } mtp_acc_s;

   mtp_acc_s    state_reg;
   mtp_acc_s    state_next;
   logic [15:0] heat_cur;
   logic [47:0] heat_sq;
   logic [47:0] full_scale;
   logic [47:0] cooling;
   logic [48:0] sum;

   // first-order thermal model: acc settles at i^2 << shift, full scale is level^2 << shift
   always_comb
   begin
      state_next = state_reg;
      heat_cur   = heating_in ? current_in : 16'h0000;
      heat_sq    = {32'h0, heat_cur} * {32'h0, heat_cur};
      full_scale = ({32'h0, level_in} * {32'h0, level_in}) << shift_in;
      cooling    = state_reg.acc >> shift_in;
      sum        = {1'b0, state_reg.acc} + {1'b0, heat_sq} - {1'b0, cooling};
      if (!enable_in)
      begin
         // disabled: no heat kept, no alarm, no trip
         state_next.acc  = 48'h0;
         state_next.pre  = 1'b0;
         state_next.trip = 1'b0;
      end
      else
      begin
         if (tick_in)
         begin
            // saturate instead of wrapping, so a long overload cannot look cool
            state_next.acc = sum[48] ? 48'hffff_ffff_ffff : sum[47:0];
         end
         // ratio test avoids a divider; drops again below 85 percent
         state_next.pre  = ({8'h0, state_reg.acc} * {48'h0, mtp_pkg::PRE_DEN}) >=
                           ({8'h0, full_scale} * {48'h0, mtp_pkg::PRE_NUM});
         state_next.trip = state_reg.acc >= full_scale;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign prealarm_out = state_reg.pre;
   assign trip_out     = state_reg.trip;

endmodule

// ---- mtp_motor_thermal_properties.sv ----
module mtp_thermal_checker
#(
   parameter int CTRL_PERIOD_CYC = 4
)
(
   input wire logic        mclk_in,
   input wire logic        arst_n_in,
   input wire logic [15:0] thermistor_ohm_in,
   input wire logic        second_set_select_in,
   input wire logic        external_overheat_in,
   input wire logic        fault_reset_in,
   input wire logic [15:0] extended_display_select_in,
   input wire logic        setting_wr_in,
   input wire logic [2:0]  setting_sel_in,
   input wire logic [15:0] setting_data_in,
   input wire logic        setting_rejected_out,
   input wire logic        heat_prealarm_out,
   input wire logic        prealarm_display_out,
   input wire logic        motor_overload_fault_out,
   input wire logic        transistor_overload_fault_out,
   input wire logic        external_relay_fault_out,
   input wire logic        thermistor_fault_out,
   input wire logic        trip_out,
   input wire logic        second_function_out,
   input wire logic        analog_cmd_enable_out,
   input wire logic        thermistor_monitor_valid_out,
   input wire logic [15:0] thermistor_monitor_out,
   input wire logic [15:0] motor_type_select_out,
   input wire logic [15:0] thermistor_trip_level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // one clock domain, so clocking and reset are given once
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   trip_from_faults_a: assert property (trip_out == (motor_overload_fault_out
      || transistor_overload_fault_out || external_relay_fault_out || thermistor_fault_out))
      else $error("trip does not follow the faults");
   display_tracks_a: assert property (prealarm_display_out == heat_prealarm_out)
      else $error("prealarm display differs from prealarm output");
   analog_release_a: assert property (analog_cmd_enable_out ==
      (thermistor_trip_level_out == 16'hffff)) else $error("analog command enable wrong");
   monitor_hidden_a: assert property (!thermistor_monitor_valid_out |->
      thermistor_monitor_out == 16'h0000) else $error("resistance shown while disabled");
   relay_trip_a: assert property (external_overheat_in [*3] |=> external_relay_fault_out)
      else $error("relay input did not trip");
   therm_trip_a: assert property (thermistor_trip_level_out != 16'hffff &&
      thermistor_ohm_in >= thermistor_trip_level_out |=> thermistor_fault_out)
      else $error("thermistor level reached without fault");
   fault_latch_a: assert property ((motor_overload_fault_out && !fault_reset_in) [*3]
      |=> motor_overload_fault_out) else $error("overload fault cleared without reset");
   second_fn_a: assert property (second_set_select_in [*2] |=> second_function_out)
      else $error("second functions not enabled");
   type_accept_a: assert property (setting_wr_in && setting_sel_in == 3'h2 &&
      setting_data_in == 16'h0001 && extended_display_select_in == 16'h0000
      |=> motor_type_select_out == 16'h0001) else $error("motor type write lost");
   type_lock_a: assert property (setting_wr_in && setting_sel_in == 3'h3 &&
      extended_display_select_in != 16'h0000 |=> setting_rejected_out)
      else $error("locked type write not refused");
endmodule
bind mtp_motor_thermal mtp_thermal_checker #(.CTRL_PERIOD_CYC(CTRL_PERIOD_CYC)) u_chk (.*);

// ---- mtp_plant_model.sv ----
module mtp_plant_model
#(
   parameter int RELAY_CODE  = 7,
   parameter int SELECT_CODE = 3,
   parameter int ALARM_CODE  = 8
)
(
   input  wire logic        mclk_in,
   input  wire logic [15:0] amps_cmd_in,
   input  wire logic [15:0] ohm_cmd_in,
   input  wire logic        relay_cmd_in,
   input  wire logic        select_cmd_in,
   input  wire logic        prealarm_in,
   output logic [15:0]      current_out = 16'h0000,
   output logic [15:0]      ohm_out = 16'h0000,
   output logic             relay_out = 1'b0,
   output logic             select_out = 1'b0,
   output logic             alarm_term_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // sensors refresh once a clock, so a step reaches the block one cycle late
   always_ff @(posedge mclk_in)
   begin
      current_out <= amps_cmd_in;
      ohm_out     <= ohm_cmd_in;
      relay_out   <= relay_cmd_in && (RELAY_CODE == 7);
      select_out  <= select_cmd_in && (SELECT_CODE == 3);
   end
   // terminal polarity follows the code given to the output terminal
   assign alarm_term_out = (ALARM_CODE == 108) ? !prealarm_in : prealarm_in;
endmodule

// ---- mtp_motor_thermal_test.sv ----
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
`define WAIT(c, n) for (int k_ = 0; k_ < n && !(c); k_++) begin @(posedge mclk_in); #1; end
module mtp_motor_thermal_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_in = 1'b0, arst_n_in = 1'b0, fault_reset_in = 1'b0, wr = 1'b0;
   logic        relay_cmd = 1'b0, sel_cmd = 1'b0, rej;
   logic [2:0]  sel = 3'h0;
   logic [15:0] data = 16'h0000, ext = 16'h0000, amps = 16'h0000, ohm = 16'h0000;
   logic [15:0] codes [9] = '{16'h0000, 16'h0001, 16'h0003, 16'h000d, 16'h0017,
                              16'h0028, 16'h002b, 16'h0032, 16'h0035};
   wire  [15:0] cur, ohm_w, m_type, s_type, s_lvl, mon, f_lvl, t_lvl;
   wire         relay_w, sel_w, rej_w, pre, pre_d, mflt, tflt, eflt, hflt, trip, sfn, ana, mval;
   int          failures = 0, total_checks = 0, cyc = 0;
   mtp_plant_model u_mtp_plant_model (.mclk_in(mclk_in), .amps_cmd_in(amps),
      .ohm_cmd_in(ohm), .relay_cmd_in(relay_cmd), .select_cmd_in(sel_cmd), .prealarm_in(pre),
      .current_out(cur), .ohm_out(ohm_w), .relay_out(relay_w), .select_out(sel_w),
      .alarm_term_out());
   // short control period keeps thermal ramps within a few thousand cycles
   mtp_motor_thermal #(.CTRL_PERIOD_CYC(4)) u_mtp_motor_thermal (.mclk_in(mclk_in),
      .arst_n_in(arst_n_in), .output_current_in(cur), .thermistor_ohm_in(ohm_w),
      .second_set_select_in(sel_w), .external_overheat_in(relay_w),
      .fault_reset_in(fault_reset_in), .extended_display_select_in(ext),
      .setting_wr_in(wr), .setting_sel_in(sel), .setting_data_in(data),
      .setting_rejected_out(rej_w), .heat_prealarm_out(pre), .prealarm_display_out(pre_d),
      .motor_overload_fault_out(mflt), .transistor_overload_fault_out(tflt),
      .external_relay_fault_out(eflt), .thermistor_fault_out(hflt), .trip_out(trip),
      .second_function_out(sfn), .analog_cmd_enable_out(ana),
      .thermistor_monitor_valid_out(mval), .thermistor_monitor_out(mon),
      .first_overload_level_out(f_lvl), .second_overload_level_out(s_lvl),
      .motor_type_select_out(m_type), .second_motor_type_out(s_type),
      .thermistor_trip_level_out(t_lvl));
   initial
   begin
      forever #25 mclk_in = ~mclk_in;
   end
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one write; the refusal pulse only stands in the cycle after the taking edge
   task automatic set(input logic [2:0] s, input logic [15:0] d, output logic r);
      @(posedge mclk_in);
      wr <= 1'b1;
      sel <= s;
      data <= d;
      @(posedge mclk_in);
      wr <= 1'b0;
      #1;
      r = rej_w;
   endtask
   // reset pin held past the two sync flops
   task automatic clear();
      @(posedge mclk_in);
      fault_reset_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      fault_reset_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      #1;
   endtask
   // hang guard well above the longest expected run
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (20) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      @(posedge mclk_in);
      #1;
      `CHK("second level", 16'hffff, s_lvl)
      `CHK("motor type", 16'h0000, m_type)
      `CHK("second type", 16'hffff, s_type)
      `CHK("analog enable", 1'b1, ana)
      foreach (codes[i])
      begin
         set(3'h2, codes[i], rej);
         `CHK("type refused", 1'b0, rej)
         `CHK("motor type", codes[i], m_type)
      end
      set(3'h2, 16'h0002, rej);
      `CHK("bad type refused", 1'b1, rej)
      set(3'h3, 16'h0001, rej);
      `CHK("second type", 16'h0001, s_type)
      set(3'h3, 16'h0002, rej);
      `CHK("bad second refused", 1'b1, rej)
      ext <= 16'h0001;
      set(3'h3, 16'hffff, rej);
      `CHK("locked refused", 1'b1, rej)
      `CHK("second type", 16'h0001, s_type)
      ext <= 16'h0000;
      set(3'h3, 16'hffff, rej);
      set(3'h4, 16'h0100, rej);
      `CHK("therm level", 16'h0100, t_lvl)
      ohm <= 16'h0080;
      repeat (4) @(posedge mclk_in);
      #1;
      `CHK("analog enable", 1'b0, ana)
      `CHK("monitor", 16'h0080, mon)
      `CHK("therm early", 1'b0, hflt)
      ohm <= 16'h0100;
      `WAIT(hflt, 6)
      `CHK("therm fault", 1'b1, trip)
      ohm <= 16'h0080;
      set(3'h4, 16'hffff, rej);
      clear();
      `CHK("monitor off", 1'b0, mval)
      relay_cmd <= 1'b1;
      `WAIT(eflt, 8)
      relay_cmd <= 1'b0;
      repeat (6) @(posedge mclk_in);
      #1;
      `CHK("relay fault held", 1'b1, eflt)
      clear();
      `CHK("relay cleared", 1'b0, trip)
      set(3'h0, 16'h0064, rej);
      amps <= 16'h005f;
      // the constant-torque curve left by the last accepted motor type write (53) heats slowly
      `WAIT(pre_d, 4000)
      `CHK("prealarm", 1'b1, pre_d)
      `CHK("no trip on prealarm", 1'b0, trip)
      amps <= 16'h0000;
      `WAIT(!pre, 200)
      `CHK("prealarm drop", 1'b0, pre)
      amps <= 16'h0078;
      `WAIT(mflt, 3000)
      `CHK("overload fault", 1'b1, mflt)
      `CHK("transistor fault", 1'b0, tflt)
      amps <= 16'h0000;
      repeat (40) @(posedge mclk_in);
      #1;
      `CHK("fault latched", 1'b1, mflt)
      clear();
      `CHK("fault cleared", 1'b0, mflt)
      set(3'h1, 16'h0032, rej);
      amps <= 16'h0040;
      repeat (1600) @(posedge mclk_in);
      #1;
      `CHK("first motor cool", 1'b0, pre)
      sel_cmd <= 1'b1;
      repeat (4) @(posedge mclk_in);
      #1;
      `CHK("second functions", 1'b1, sfn)
      `WAIT(mflt, 3000)
      `CHK("second level trip", 1'b1, mflt)
      amps <= 16'h0000;
      sel_cmd <= 1'b0;
      clear();
      set(3'h0, 16'h0000, rej);
      `CHK("first level", 16'h0000, f_lvl)
      set(3'h1, 16'hffff, rej);
      amps <= 16'h0100;
      repeat (1600) @(posedge mclk_in);
      #1;
      `CHK("disabled prealarm", 1'b0, pre)
      `CHK("disabled trip", 1'b0, trip)
      amps <= 16'h0258;
      `WAIT(tflt, 400)
      `CHK("transistor fault", 1'b1, tflt)
      `CHK("motor level off", 1'b0, mflt)
      tally_and_finish();
   end
endmodule
